// ==== verilog/edr_top.sv ====
// edr_top: secded protected two-port ram with scrubber, codec mode and apb status
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module edr_top
    import edr_pkg::*;
#(
    parameter int K          = EDR_DATA_W_DEF,
    parameter int R          = EDR_PAR_W_DEF,
    parameter int DEPTH      = EDR_DEPTH_DEF,
    parameter bit TMR        = 1'b0,
    parameter bit EXT_RAM    = 1'b0,
    parameter bit TEST       = 1'b1,
    parameter bit SCRUB_ON   = 1'b1,
    parameter bit INIT_RAM   = 1'b1,
    parameter bit ADDR_MATCH = 1'b1,
    localparam int N         = K + R,
    localparam int AW        = $clog2(DEPTH),
    localparam int UW        = K + 2 * AW + 5
) (
    input  wire logic          i_mclk,
    input  wire logic          i_reset,
    input  wire logic          i_global_async_reset_n,
    input  wire edr_apb_req_t  i_apb,
    output edr_apb_rsp_t       o_apb,
    input  wire logic [K-1:0]  i_write_word_in,
    input  wire logic          i_user_write_enable,
    input  wire logic [AW-1:0] i_user_write_addr,
    input  wire logic          i_user_read_enable,
    input  wire logic [AW-1:0] i_user_read_addr,
    input  wire logic          i_scrub_halt_in,
    input  wire logic          i_scrub_launch_in,
    input  wire logic          i_scrub_interval_restart,
    input  wire logic [UW-1:0] i_copy2,
    input  wire logic [UW-1:0] i_copy3,
    input  wire logic [N-1:0]  i_external_codeword_in,
    input  wire logic [N-1:0]  i_fault_inject_mask,
    output logic      [K-1:0]  o_read_data,
    output logic      [R-1:0]  o_read_parity,
    output logic               o_read_valid,
    output logic      [AW-1:0] o_delayed_read_addr_out,
    output logic               o_error_flag,
    output logic               o_correctable_flag,
    output logic               o_init_done,
    output logic      [N-1:0]  o_encoded_word_out,
    output logic      [N-1:0]  o_raw_codeword,
    output logic               o_scrub_active_flag,
    output logic               o_scrub_done,
    output logic               o_scrub_throttle_flag,
    output logic               o_scrub_timeout_flag
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (K < 1 || R < 4 || ((1 << (R - 1)) - R) < K) begin : g_bad_code
        $error("edr_top: parity width too small for data width");
    end
    if (DEPTH < 2 || AW > 16) begin : g_bad_depth
        $error("edr_top: depth out of range");
    end

    // ------------------------------------------------------------
    // hsiao codec
    // ------------------------------------------------------------
    typedef struct packed {
        logic [K-1:0] data;
        logic [R-1:0] par;
        logic         err;
        logic         cor;
    } dec_t;

    // column of data bit idx: odd weight of three or more
    function automatic logic [R-1:0] hcol(input int idx);
        int          n;
        logic [R-1:0] v;
        hcol = '0;
        n = 0;
        for (int c = 1; c < (1 << R); c++) begin
            v = R'(c);
            if ($countones(v) >= 3 && ($countones(v) % 2) == 1) begin
                if (n == idx) hcol = v;
                n++;
            end
        end
    endfunction

    function automatic logic [R-1:0] parity(input logic [K-1:0] d);
        parity = '0;
        for (int i = 0; i < K; i++) begin
            if (d[i]) parity = parity ^ hcol(i);
        end
    endfunction

    function automatic dec_t decode(input logic [N-1:0] cw);
        logic [R-1:0] syn;
        syn = cw[R-1:0] ^ parity(cw[N-1:R]);
        decode.data = cw[N-1:R];
        decode.par  = cw[R-1:0];
        decode.err  = |syn;
        decode.cor  = 1'b0;
        for (int i = 0; i < K; i++) begin
            if (syn == hcol(i)) begin
                decode.data[i] = ~decode.data[i];
                decode.cor     = 1'b1;
            end
        end
        for (int j = 0; j < R; j++) begin
            if (syn == R'(1 << j)) begin
                decode.par[j] = ~decode.par[j];
                decode.cor    = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // input voting
    // ------------------------------------------------------------
    logic [UW-1:0] in1, uv;
    logic [K-1:0]  u_wdata;
    logic [AW-1:0] u_waddr, u_raddr;
    logic          u_wen, u_ren, u_halt, u_launch, u_restart;

    assign in1 = {i_write_word_in, i_user_write_enable, i_user_write_addr,
                  i_user_read_enable, i_user_read_addr, i_scrub_halt_in,
                  i_scrub_launch_in, i_scrub_interval_restart};
    assign uv = TMR ? ((in1 & i_copy2) | (in1 & i_copy3) | (i_copy2 & i_copy3)) : in1;
    assign {u_wdata, u_wen, u_waddr, u_ren, u_raddr, u_halt, u_launch, u_restart} = uv;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        edr_fsm_t                 fsm;
        logic [AW-1:0]            saddr;
        logic                     rd_vld;
        logic                     rd_scrub;
        logic [AW-1:0]            rd_addr;
        logic [N-1:0]             cw;
        logic [K-1:0]             out_data;
        logic [R-1:0]             out_par;
        logic                     out_vld;
        logic [AW-1:0]            out_addr;
        logic                     err;
        logic                     cor;
        logic [N-1:0]             enc;
        logic [EDR_TIMER_W-1:0]   timer;
        logic                     tmo;
        logic                     done;
        logic                     throttle;
        logic                     init_done;
        logic                     ctrl_en;
        logic [EDR_TIMER_W-1:0]   period;
        logic [15:0]              errcnt;
        edr_apb_rsp_t             apb;
    } st_t;

    localparam st_t ST_ASYNC = '{fsm: (INIT_RAM ? EDR_S_INIT : EDR_S_IDLE),
                                 init_done: !INIT_RAM, ctrl_en: EDR_CTRL_EN_RST,
                                 period: EDR_PERIOD_RST, default: '0};
    localparam st_t ST_SYNC  = '{fsm: EDR_S_IDLE, init_done: 1'b1,
                                 ctrl_en: EDR_CTRL_EN_RST,
                                 period: EDR_PERIOD_RST, default: '0};

    st_t          q, d;
    logic [N-1:0] mem [DEPTH];
    logic         mem_we, mem_re, busy, acc, unmapped, expired, can_scrub;
    logic [AW-1:0] mem_wa, mem_ra;
    logic [N-1:0] mem_wd, inj;
    dec_t         dec;

    assign dec = decode(q.cw);
    assign inj = TEST ? i_fault_inject_mask : '0;
    // user access without halt throttles scrub
    assign busy = u_wen | u_ren;
    assign expired = (q.timer >= q.period);
    assign can_scrub = SCRUB_ON && !EXT_RAM && q.ctrl_en;
    assign acc = i_apb.psel & i_apb.penable;
    assign unmapped = !(i_apb.paddr inside {EDR_OFS_CTRL, EDR_OFS_PERIOD,
                                            EDR_OFS_STATUS, EDR_OFS_ERRCNT});

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.throttle = 1'b0;
        d.out_vld = 1'b0;
        mem_we = u_wen & !EXT_RAM;
        mem_wa = u_waddr;
        mem_wd = {u_wdata, parity(u_wdata)} ^ inj;
        mem_re = u_ren;
        mem_ra = u_raddr;
        d.rd_scrub = 1'b0;
        if (u_wen) d.enc = {u_wdata, parity(u_wdata)} ^ inj;
        if (q.timer != '1) d.timer = q.timer + 1'b1;
        if (u_restart) d.timer = '0;
        case (q.fsm)
            EDR_S_INIT: begin
                mem_we = 1'b1;
                mem_wa = q.saddr;
                mem_wd = {{K{1'b0}}, parity('0)};
                mem_re = 1'b0;
                d.saddr = q.saddr + 1'b1;
                if (q.saddr == AW'(DEPTH - 1)) begin
                    d.fsm = EDR_S_IDLE;
                    d.saddr = '0;
                    d.init_done = 1'b1;
                end
            end
            EDR_S_IDLE: begin
                if (can_scrub && expired && u_halt) d.tmo = 1'b1;
                if (can_scrub && !u_halt && (u_launch || expired || q.tmo)) begin
                    d.fsm = EDR_S_READ;
                    d.saddr = '0;
                    d.timer = '0;
                    d.tmo = 1'b0;
                end
            end
            EDR_S_READ, EDR_S_CHECK: begin
                d.timer = '0;
                if (u_halt) begin
                    d.fsm = EDR_S_IDLE;
                end else if (busy) begin
                    d.throttle = 1'b1;
                    d.fsm = EDR_S_READ;
                end else if (q.fsm == EDR_S_READ) begin
                    mem_re = 1'b1;
                    mem_ra = q.saddr;
                    d.rd_scrub = 1'b1;
                    d.fsm = EDR_S_CHECK;
                end else begin
                    mem_we = dec.err & dec.cor;
                    mem_wa = q.saddr;
                    mem_wd = {dec.data, dec.par};
                    d.saddr = q.saddr + 1'b1;
                    d.fsm = EDR_S_READ;
                    if (q.saddr == AW'(DEPTH - 1)) begin
                        d.fsm = EDR_S_IDLE;
                        d.done = 1'b1;
                    end
                end
            end
            default: d.fsm = EDR_S_IDLE;
        endcase
        d.rd_vld = mem_re;
        d.rd_addr = mem_ra;
        if (mem_re) d.cw = EXT_RAM ? i_external_codeword_in : mem[mem_ra];
        if (q.rd_vld && !q.rd_scrub) begin
            d.out_vld = 1'b1;
            d.out_data = dec.data;
            d.out_par = dec.par;
            d.err = dec.err;
            d.cor = dec.cor;
            d.out_addr = ADDR_MATCH ? q.rd_addr : '0;
        end
        // apb slave, one wait state
        d.apb.pready = acc & !q.apb.pready;
        if (acc && !q.apb.pready) begin
            d.apb.pslverr = unmapped;
            d.apb.prdata = '0;
            case (i_apb.paddr)
                EDR_OFS_CTRL:   d.apb.prdata[EDR_CTRL_EN_BIT] = q.ctrl_en;
                EDR_OFS_PERIOD: d.apb.prdata[EDR_TIMER_W-1:0] = q.period;
                EDR_OFS_STATUS: begin
                    d.apb.prdata[EDR_ST_ACTIVE_BIT]   = o_scrub_active_flag;
                    d.apb.prdata[EDR_ST_INIT_BIT]     = q.init_done;
                    d.apb.prdata[EDR_ST_TMO_BIT]      = q.tmo;
                    d.apb.prdata[EDR_ST_THROTTLE_BIT] = q.throttle;
                    d.apb.prdata[EDR_ST_ERR_BIT]      = q.err;
                    d.apb.prdata[EDR_ST_COR_BIT]      = q.cor;
                end
                EDR_OFS_ERRCNT: d.apb.prdata[15:0] = q.errcnt;
                default:        d.apb.prdata = '0;
            endcase
        end
        if (acc && q.apb.pready && i_apb.pwrite) begin
            if (i_apb.paddr == EDR_OFS_CTRL) begin
                d.ctrl_en = i_apb.pwdata[EDR_CTRL_EN_BIT];
                if (i_apb.pwdata[EDR_CTRL_CLR_BIT]) d.errcnt = '0;
            end
            if (i_apb.paddr == EDR_OFS_PERIOD) d.period = i_apb.pwdata[EDR_TIMER_W-1:0];
        end
        // count after clear so a correction in the clear cycle survives
        if (q.rd_vld && dec.cor && q.errcnt != '1) d.errcnt = d.errcnt + 1'b1;
        if (i_reset) d = ST_SYNC;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // both resets
    always_ff @(posedge i_mclk or negedge i_global_async_reset_n) begin
        if (!i_global_async_reset_n) begin
            q <= ST_ASYNC;
        end else begin
            q <= d;
        end
    end

    // ram contents survive both resets; only init clears them
    always_ff @(posedge i_mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_apb                  = q.apb;
    assign o_read_data            = q.out_data;
    assign o_read_parity          = q.out_par;
    assign o_read_valid           = q.out_vld;
    assign o_delayed_read_addr_out = q.out_addr;
    assign o_error_flag           = q.err;
    assign o_correctable_flag     = q.cor;
    assign o_init_done            = q.init_done;
    assign o_encoded_word_out     = q.enc;
    assign o_raw_codeword         = q.cw;
    assign o_scrub_active_flag    = (q.fsm == EDR_S_READ) || (q.fsm == EDR_S_CHECK);
    assign o_scrub_done           = q.done;
    assign o_scrub_throttle_flag  = q.throttle;
    assign o_scrub_timeout_flag   = q.tmo;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset || !i_global_async_reset_n);

    sequence s_user_read;
        u_ren && q.fsm != EDR_S_INIT;
    endsequence
    sequence s_out_two_later;
        ##2 o_read_valid;
    endsequence

    chk_read_latency: assert property (s_user_read |-> s_out_two_later)
        else $error("user read gave no output two cycles later");
    chk_addr_match: assert property (s_user_read |-> ##2 (!ADDR_MATCH ||
        o_delayed_read_addr_out == $past(u_raddr, 2)))
        else $error("delayed read address mismatch");
    chk_halt_abort: assert property (u_halt |=> q.fsm inside {EDR_S_IDLE, EDR_S_INIT})
        else $error("scrub running while halted");
    chk_launch_start: assert property (u_launch && !u_halt && can_scrub &&
        q.fsm == EDR_S_IDLE |=> o_scrub_active_flag)
        else $error("launch did not start scrub");
    chk_timer_restart: assert property (u_restart |=> q.timer == '0)
        else $error("timer not restarted");
    chk_done_pulse: assert property (o_scrub_done |-> !o_scrub_active_flag ##1 !o_scrub_done)
        else $error("scrub done not a single pulse");
    chk_cor_err: assert property (o_correctable_flag |-> o_error_flag)
        else $error("correctable flag without error flag");
    chk_writeback_err: assert property (q.fsm == EDR_S_CHECK && !busy && !u_halt
        && mem_we |-> dec.err && dec.cor)
        else $error("scrub write without detected error");
    chk_sync_reset: assert property (@(posedge i_mclk) disable iff (!i_global_async_reset_n)
        i_reset |=> q.fsm == EDR_S_IDLE && o_init_done)
        else $error("sync reset did not return to idle");

endmodule

// ==== verilog/edr_pkg.sv ====
// edr_pkg: shared constants and carrier types of the protected ram block
package edr_pkg;

    // ------------------------------------------------------------
    // default geometry
    // ------------------------------------------------------------
    localparam int EDR_DATA_W_DEF   = 8;
    localparam int EDR_PAR_W_DEF    = 5;
    localparam int EDR_DEPTH_DEF    = 256;

    // ------------------------------------------------------------
    // register map, byte addresses on the apb bus
    // ------------------------------------------------------------
    localparam logic [11:0] EDR_OFS_CTRL    = 12'h000;
    localparam logic [11:0] EDR_OFS_PERIOD  = 12'h004;
    localparam logic [11:0] EDR_OFS_STATUS  = 12'h008;
    localparam logic [11:0] EDR_OFS_ERRCNT  = 12'h00C;

    // ctrl fields
    localparam int          EDR_CTRL_EN_BIT  = 0;
    localparam int          EDR_CTRL_CLR_BIT = 1;
    localparam logic        EDR_CTRL_EN_RST  = 1'h1;

    // status fields
    localparam int EDR_ST_ACTIVE_BIT   = 0;
    localparam int EDR_ST_INIT_BIT     = 1;
    localparam int EDR_ST_TMO_BIT      = 2;
    localparam int EDR_ST_THROTTLE_BIT = 3;
    localparam int EDR_ST_ERR_BIT      = 4;
    localparam int EDR_ST_COR_BIT      = 5;

    // scrub interval in clock cycles after reset
    localparam logic [15:0] EDR_PERIOD_RST  = 16'h1000;
    localparam int          EDR_TIMER_W     = 16;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EDR_S_IDLE  = 2'b00,
        EDR_S_INIT  = 2'b01,
        EDR_S_READ  = 2'b10,
        EDR_S_CHECK = 2'b11
    } edr_fsm_t;

    // ------------------------------------------------------------
    // apb carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } edr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } edr_apb_rsp_t;

endpackage

// ==== bench/edr_user_model.sv ====
// edr_user_model: user logic that drives the write and read ports of the ram
`timescale 1ns/1ns
module edr_user_model #(
    parameter int K  = 8,
    parameter int N  = 13,
    parameter int AW = 4
) (
    input  wire logic     i_mclk,
    output logic          o_wen,
    output logic [AW-1:0] o_waddr,
    output logic [K-1:0]  o_wdata,
    output logic          o_ren,
    output logic [AW-1:0] o_raddr,
    output logic [N-1:0]  o_mask
);
    initial begin
        o_wen = 1'b0;
        o_ren = 1'b0;
        o_waddr = '0;
        o_wdata = '0;
        o_raddr = '0;
        o_mask = '0;
    end

    task automatic wr_word(input logic [AW-1:0] a, input logic [K-1:0] d, input logic [N-1:0] m);
        o_wen <= 1'b1;
        o_waddr <= a;
        o_wdata <= d;
        o_mask <= m;
        @(posedge i_mclk);
    endtask

    task automatic rd_word(input logic [AW-1:0] a);
        o_ren <= 1'b1;
        o_raddr <= a;
        @(posedge i_mclk);
    endtask

    // released address and data lines show inverted stale values so nothing leans on the last word
    task automatic quiet();
        o_wen <= 1'b0;
        o_ren <= 1'b0;
        o_waddr <= ~o_waddr;
        o_wdata <= ~o_wdata;
        o_raddr <= ~o_raddr;
        o_mask <= '0;
        @(posedge i_mclk);
    endtask
endmodule

// ==== bench/edr_top_tb.sv ====
// edr_top_tb: self-checking bench of the protected ram block
`timescale 1ns/1ns
module edr_top_tb;
    import edr_pkg::*;
    localparam int K = 8;
    localparam int R = 5;
    localparam int N = 13;
    localparam int AW = 4;
    typedef struct packed {
        logic [K-1:0]  data;
        logic [K-1:0]  raw_hi;
        logic [AW-1:0] addr;
        logic          err;
        logic          cor;
        logic          dchk;
    } edr_exp_t;
    logic mclk = 1'b0, rst = 1'b1, arst_n = 1'b1, halt = 1'b1, launch = 1'b0, restart = 1'b0;
    logic [N-1:0] ext = '0, enc, raw, raw_prev = '0, mask;
    logic [K-1:0] wdata, rdata, mem [16];
    logic [AW-1:0] waddr, raddr, daddr;
    logic [R-1:0] rpar;
    logic wen, ren, rvalid, err, cor, initd, act, done, thr, tmo, se, seen;
    logic [31:0] q;
    edr_apb_req_t apb_q = '0;
    edr_apb_rsp_t apb_r;
    edr_exp_t ev;
    edr_exp_t exp_q [$];
    int mismatches = 0, cmp_count = 0, cyc = 0, seed = 3, n;

    always #25 mclk = ~mclk;

    edr_user_model #(.K(K), .N(N), .AW(AW)) i_edr_user_model (
        .i_mclk(mclk), .o_wen(wen), .o_waddr(waddr), .o_wdata(wdata),
        .o_ren(ren), .o_raddr(raddr), .o_mask(mask));

    // single clock, only first copy driven
    edr_top #(.DEPTH(16)) i_edr_top (
        .i_mclk(mclk), .i_reset(rst), .i_global_async_reset_n(arst_n),
        .i_apb(apb_q), .o_apb(apb_r), .i_write_word_in(wdata),
        .i_user_write_enable(wen), .i_user_write_addr(waddr),
        .i_user_read_enable(ren), .i_user_read_addr(raddr), .i_scrub_halt_in(halt),
        .i_scrub_launch_in(launch), .i_scrub_interval_restart(restart),
        .i_copy2('0), .i_copy3('0), .i_external_codeword_in(ext),
        .i_fault_inject_mask(mask), .o_read_data(rdata), .o_read_parity(rpar),
        .o_read_valid(rvalid), .o_delayed_read_addr_out(daddr), .o_error_flag(err),
        .o_correctable_flag(cor), .o_init_done(initd), .o_encoded_word_out(enc),
        .o_raw_codeword(raw), .o_scrub_active_flag(act), .o_scrub_done(done),
        .o_scrub_throttle_flag(thr), .o_scrub_timeout_flag(tmo));

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        apb_q <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk);
        apb_q.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_r.pready !== 1'b1 && n < 50);
        check("apb ready", apb_r.pready, 1'b1);
        q = apb_r.prdata;
        se = apb_r.pslverr;
        apb_q <= '0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [K-1:0] rh, input logic e, input logic c);
        exp_q.push_back('{mem[a], rh, a, e, c, !(e && !c)});
        i_edr_user_model.rd_word(a);
    endtask

    // codeword input is noise with internal ram
    always @(posedge mclk) begin
        ext <= N'($random(seed));
        raw_prev <= raw;
        cyc <= cyc + 1;
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare valid", 1'b1, 1'b0);
            end else begin
                ev = exp_q.pop_front();
                if (ev.dchk) check("data", rdata, ev.data);
                if (ev.dchk) check("parity", rpar, raw_prev[R-1:0]);
                check("raw", raw_prev[N-1:R], ev.raw_hi);
                check("addr", daddr, ev.addr);
                check("err", err, ev.err);
                check("cor", cor, ev.cor);
            end
        end
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        arst_n <= 1'b0;
        @(posedge mclk);
        arst_n <= 1'b1;
        check("init low", initd, 1'b0);
        for (n = 0; n < 40 && initd !== 1'b1; n++) @(posedge mclk);
        check("init done", initd, 1'b1);
        apb(1'b0, EDR_OFS_STATUS, '0);
        check("status init", q[EDR_ST_INIT_BIT], 1'b1);
        apb(1'b0, 12'h010, '0);
        check("unmapped err", se, 1'b1);
        check("unmapped data", q, 32'h0);
        apb(1'b1, EDR_OFS_PERIOD, 32'h0000_0014);
        $display("test reset and registers done");
        for (int a = 15; a >= 0; a--) begin
            mem[a] = K'($random(seed));
            i_edr_user_model.wr_word(AW'(a), mem[a], a == 1 ? 13'h0100 : a == 0 ? 13'h0300 : '0);
        end
        i_edr_user_model.quiet();
        check("encoded", enc[N-1:R], mem[0] ^ 8'h18);
        for (int a = 0; a < 16; a++) begin
            rd(AW'(a), a == 1 ? mem[1] ^ 8'h08 : a == 0 ? mem[0] ^ 8'h18 : mem[a], a < 2, a == 1);
        end
        i_edr_user_model.quiet();
        repeat (4) @(posedge mclk);
        check("timeout", tmo, 1'b1);
        $display("test write and read done");
        halt <= 1'b0;
        for (n = 0; n < 3 && act !== 1'b1; n++) @(posedge mclk);
        check("scrub active", act, 1'b1);
        for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge mclk);
        check("scrub done", done, 1'b1);
        halt <= 1'b1;
        rd(1, mem[1], 1'b0, 1'b0);
        rd(0, mem[0] ^ 8'h18, 1'b1, 1'b0);
        i_edr_user_model.quiet();
        repeat (4) @(posedge mclk);
        $display("test scrub session done");
        restart <= 1'b1;
        repeat (30) @(posedge mclk);
        check("restart holds timer", tmo, 1'b0);
        restart <= 1'b0;
        repeat (25) @(posedge mclk);
        check("timeout after restart", tmo, 1'b1);
        $display("test timer restart done");
        launch <= 1'b1;
        repeat (4) @(posedge mclk);
        check("halted launch", act, 1'b0);
        halt <= 1'b0;
        for (n = 0; n < 3 && act !== 1'b1; n++) @(posedge mclk);
        check("launch", act, 1'b1);
        // access without halt on purpose: the scrub must yield
        rd(2, mem[2], 1'b0, 1'b0);
        i_edr_user_model.quiet();
        check("throttle", thr, 1'b1);
        launch <= 1'b0;
        halt <= 1'b1;
        seen = 1'b0;
        repeat (3) begin
            @(posedge mclk);
            seen = seen | done;
        end
        check("abort", {act, seen}, 2'b00);
        $display("test halt and launch done");
        apb(1'b0, EDR_OFS_ERRCNT, '0);
        check("corrections", q, 32'h2);
        apb(1'b1, EDR_OFS_CTRL, 32'h0000_0002);
        apb(1'b0, EDR_OFS_ERRCNT, '0);
        check("count cleared", q, 32'h0);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        check("no init on sync reset", initd, 1'b1);
        apb(1'b0, EDR_OFS_CTRL, '0);
        check("ctrl reset", q[EDR_CTRL_EN_BIT], EDR_CTRL_EN_RST);
        $display("test sync reset done");
        close_out();
    end
endmodule
